// >>> pgc_pattern_gen.sv
// Pattern generator with PRBS sources, clock patterns and clocking setup
`include "pgc_consts.svh"
`default_nettype none
// Function
// - LFSR repeats after 2^n-1, run limits
// - Fibonacci default, Galois by build option
// - Sources muxed, registered, 16/20/32/40 bits
// - Select 0: alternating ones and zeros
// - Select 1: runs of five or four
// - Select 2: runs of ten or eight
// - Select 3: PRBS7 x^7+x^6+1 plain
// - Select 4: PRBS9 x^9+x^5+1 plain
// - Select 5: PRBS11 x^11+x^9+1 plain
// - Select 6: PRBS15 x^15+x^14+1
// - Select 7: PRBS20 x^20+x^3+1 plain
// - Select 8: PRBS23 x^23+x^18+1 inverted
// - Select 9: PRBS29 x^29+x^27+1 inverted
// - Select 10: PRBS31 x^31+x^28+1 inverted
// - Ref modules one and two enable own tree
// - Low-rate global reference path is removable
// - Recovered clock buffered, clocks receive side
// - Column master tx clock drives column
// - Column shares rate; master PLL must lock
// - Options: master, per-channel tx, synchronous
// - Internal dividers; no parallel loopback
// - Error inject flips output bit zero
// - Immediate from seed in three cycles
module pgc_pattern_gen
    import pgc_pkg::*;
#(
    parameter bit GALOIS = 1'b0,
    parameter bit LOWRATE_REF_EN = 1'b1,
    parameter logic [3:0] TX_MASTER_CHANNEL = 4'h0,
    parameter bit PER_CHANNEL_TX_CLOCK = 1'b0,
    parameter bit RX_CLOCK_FROM_TX = 1'b0
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic [3:0] pattern_sel_i,
    input wire pgc_width_t width_sel_i,
    input wire logic immediate_mode_i,
    input wire logic [39:0] seed_i,
    input wire logic invert_i,
    input wire logic error_inject_i,
    input wire logic tx_master_pll_locked_i,
    output logic [39:0] data_o,
    output logic data_valid_o,
    output pgc_clk_cfg_t clk_cfg_o
);
    localparam int unsigned LENS [`PGC_NUM_PRBS] = `PGC_PRBS_LENS;
    localparam int unsigned TAPS [`PGC_NUM_PRBS] = `PGC_PRBS_TAPS;
    localparam logic [7:0] INV_DEFAULT = `PGC_PRBS_INV_DEFAULT;

    pgc_gen_st_t st_q;
    pgc_gen_st_t st_d;
    logic [39:0] lane_word [`PGC_NUM_PRBS];
    logic [5:0] bits;
    logic [39:0] wmask;

    always_comb begin
        case (st_q.width)
            PGC_W16: begin
                bits = `PGC_BITS_16;
                wmask = `PGC_MASK_16;
            end
            PGC_W20: begin
                bits = `PGC_BITS_20;
                wmask = `PGC_MASK_20;
            end
            PGC_W32: begin
                bits = `PGC_BITS_32;
                wmask = `PGC_MASK_32;
            end
            default: begin
                bits = `PGC_BITS_40;
                wmask = `PGC_MASK_40;
            end
        endcase
    end

    // eight PRBS sources, one per polynomial
    genvar g;
    generate
        for (g = 0; g < `PGC_NUM_PRBS; g++) begin : g_prbs
            pgc_lfsr_lane #(
                .N(LENS[g]),
                .TAP(TAPS[g]),
                .GALOIS(GALOIS)
            ) u_lane (
                .mclk_i(mclk_i),
                .sys_rst_i(sys_rst_i),
                .ce_i(ce_i),
                .advance_i(st_q.locked),
                .immediate_i(st_q.immediate),
                .seed_i(st_q.seed),
                .bits_i(bits),
                .word_o(lane_word[g])
            );
        end
    endgenerate

    always_comb begin
        logic [39:0] w;
        logic [3:0] idx;
        logic inv;
        w = '0;
        idx = '0;
        inv = 1'b0;
        st_d = st_q;
        // seed and controls enter stage one
        st_d.seed = seed_i;
        st_d.immediate = immediate_mode_i;
        st_d.sel = pattern_sel_i;
        st_d.width = width_sel_i;
        // column stalls until master PLL locks
        st_d.locked = tx_master_pll_locked_i;
        case (st_q.sel)
            `PGC_SEL_CLK_HALF: begin
                w = `PGC_CLK_HALF_WORD;
            end
            `PGC_SEL_CLK_TENTH: begin
                if (st_q.width == PGC_W20 || st_q.width == PGC_W40) begin
                    w = `PGC_CLK_RUN5_WORD;
                end else begin
                    w = `PGC_CLK_RUN4_WORD;
                end
            end
            `PGC_SEL_CLK_TWENTIETH: begin
                // Whole periods fit every width, so no phase state
                if (st_q.width == PGC_W20 || st_q.width == PGC_W40) begin
                    w = `PGC_CLK_RUN10_WORD;
                end else begin
                    w = `PGC_CLK_RUN8_WORD;
                end
            end
            default: begin
                // PRBS23 up are inverted by default
                if (st_q.sel >= `PGC_SEL_PRBS_FIRST && st_q.sel <= `PGC_SEL_PRBS_LAST) begin
                    idx = st_q.sel - `PGC_SEL_PRBS_FIRST;
                    inv = INV_DEFAULT[idx[2:0]];
                    inv = inv ^ invert_i;
                    w = lane_word[idx[2:0]] ^ {40{inv}};
                end else begin
                    // Unbuilt or reserved selections send zeros
                    w = '0;
                end
            end
        endcase
        w = w & wmask;
        w[`PGC_ERR_BIT] = w[`PGC_ERR_BIT] ^ error_inject_i;
        if (st_q.locked) begin
            st_d.data = w;
        end
        st_d.valid = st_q.locked;
        // each ref module drives one tree only
        st_d.clk_cfg.tree_one_output_enable = `PGC_TREE_ONE_EN;
        st_d.clk_cfg.tree_two_output_enable = `PGC_TREE_TWO_EN;
        st_d.clk_cfg.global_lowrate_reference_en = LOWRATE_REF_EN;
        st_d.clk_cfg.tx_master_channel = TX_MASTER_CHANNEL;
        st_d.clk_cfg.per_channel_tx_clock = PER_CHANNEL_TX_CLOCK;
        st_d.clk_cfg.rx_clock_from_tx = RX_CLOCK_FROM_TX;
        st_d.clk_cfg.internal_dividers = 1'b1;
        st_d.clk_cfg.parallel_loopback_ok = 1'b0;
        // whole column depends on the lock
        st_d.clk_cfg.column_tx_ok = st_q.locked;
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q <= '0;
        end else if (ce_i) begin
            st_q <= st_d;
        end
    end

    assign data_o = st_q.data;
    assign data_valid_o = st_q.valid;
    assign clk_cfg_o = st_q.clk_cfg;

endmodule // pgc_pattern_gen
`default_nettype wire

// >>> pgc_consts.svh
// Constants for the PRBS and clock pattern generator
`ifndef PGC_CONSTS_SVH
`define PGC_CONSTS_SVH

`define PGC_DATA_W 40
`define PGC_LFSR_W 31
`define PGC_NUM_PRBS 8

`define PGC_SEL_CLK_HALF 4'h0
`define PGC_SEL_CLK_TENTH 4'h1
`define PGC_SEL_CLK_TWENTIETH 4'h2
`define PGC_SEL_PRBS_FIRST 4'h3
`define PGC_SEL_PRBS_LAST 4'hA

`define PGC_BITS_16 6'h10
`define PGC_BITS_20 6'h14
`define PGC_BITS_32 6'h20
`define PGC_BITS_40 6'h28

`define PGC_MASK_16 40'h000000FFFF
`define PGC_MASK_20 40'h00000FFFFF
`define PGC_MASK_32 40'h00FFFFFFFF
`define PGC_MASK_40 40'hFFFFFFFFFF

`define PGC_CLK_HALF_WORD 40'hAAAAAAAAAA
`define PGC_CLK_RUN5_WORD 40'hF83E0F83E0
`define PGC_CLK_RUN4_WORD 40'hF0F0F0F0F0
`define PGC_CLK_RUN10_WORD 40'hFFC00FFC00
`define PGC_CLK_RUN8_WORD 40'h00FF00FF00

`define PGC_PRBS_LENS '{7, 9, 11, 15, 20, 23, 29, 31}
`define PGC_PRBS_TAPS '{6, 5, 9, 14, 3, 18, 27, 28}
`define PGC_PRBS_INV_DEFAULT 8'hE0

`define PGC_TREE_ONE_EN 4'h5
`define PGC_TREE_TWO_EN 4'hA
`define PGC_ERR_BIT 0

`endif

// >>> pgc_pkg.sv
// Types shared by the pattern generator files
`default_nettype none
package pgc_pkg;

    typedef enum logic [1:0] {
        PGC_W16,
        PGC_W20,
        PGC_W32,
        PGC_W40
    } pgc_width_t;

    typedef struct packed {
        logic [30:0] lfsr;
        logic [39:0] word;
    } pgc_lane_st_t;

    typedef struct packed {
        logic [3:0] tree_one_output_enable;
        logic [3:0] tree_two_output_enable;
        logic global_lowrate_reference_en;
        logic [3:0] tx_master_channel;
        logic per_channel_tx_clock;
        logic rx_clock_from_tx;
        logic internal_dividers;
        logic parallel_loopback_ok;
        logic column_tx_ok;
    } pgc_clk_cfg_t;

    typedef struct packed {
        logic [39:0] seed;
        logic immediate;
        logic [3:0] sel;
        pgc_width_t width;
        logic locked;
        logic [39:0] data;
        logic valid;
        pgc_clk_cfg_t clk_cfg;
    } pgc_gen_st_t;

endpackage
`default_nettype wire

// >>> pgc_lfsr_lane.sv
// One parallel LFSR pattern source
`include "pgc_consts.svh"
`default_nettype none
module pgc_lfsr_lane
    import pgc_pkg::*;
#(
    parameter int unsigned N = 7,
    parameter int unsigned TAP = 6,
    parameter bit GALOIS = 1'b0
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic advance_i,
    input wire logic immediate_i,
    input wire logic [39:0] seed_i,
    input wire logic [5:0] bits_i,
    output logic [39:0] word_o
);
    localparam logic [30:0] MASK = 31'((64'h1 << N) - 64'h1);
    localparam logic [30:0] GMASK = 31'((64'h1 << (N - TAP)) | 64'h1);

    pgc_lane_st_t st_q;
    pgc_lane_st_t st_d;

    always_comb begin
        logic [30:0] s;
        logic fb;
        logic [39:0] w;
        s = '0;
        fb = 1'b0;
        w = '0;
        st_d = st_q;
        s = immediate_i ? (seed_i[30:0] & MASK) : st_q.lfsr;
        if (s == '0) begin
            s = MASK;
        end
        for (int i = 0; i < `PGC_DATA_W; i++) begin
            if (6'(i) < bits_i) begin
                if (GALOIS) begin
                    fb = s[N-1];
                    s = (s << 1) & MASK;
                    if (fb) begin
                        s = s ^ GMASK;
                    end
                end else begin
                    fb = s[N-1] ^ s[TAP-1];
                    s = ((s << 1) | 31'(fb)) & MASK;
                end
                // First bit out lands in the word's top used bit
                w = {w[38:0], fb};
            end
        end
        if (advance_i) begin
            st_d.word = w;
            st_d.lfsr = s;
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q.lfsr <= MASK;
            st_q.word <= '0;
        end else if (ce_i) begin
            st_q <= st_d;
        end
    end

    assign word_o = st_q.word;

endmodule // pgc_lfsr_lane
`default_nettype wire

// >>> pgc_pattern_gen_asserts.sv
// Port assertions for the pattern generator
`default_nettype none
module pgc_pattern_gen_asserts import pgc_pkg::*; (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic [3:0] pattern_sel_i,
    input wire pgc_width_t width_sel_i,
    input wire logic error_inject_i,
    input wire logic tx_master_pll_locked_i,
    input wire logic [39:0] data_o,
    input wire logic data_valid_o,
    input wire pgc_clk_cfg_t clk_cfg_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);
    tree_en_a: assert property (!$past(sys_rst_i) && $past(ce_i) |->
        clk_cfg_o.tree_one_output_enable == 4'h5 && clk_cfg_o.tree_two_output_enable == 4'hA)
        else $error("tree enables wrong");
    cfg_static_a: assert property (!$past(sys_rst_i) && $past(ce_i) |->
        clk_cfg_o.global_lowrate_reference_en && clk_cfg_o.internal_dividers
        && !clk_cfg_o.parallel_loopback_ok && !clk_cfg_o.per_channel_tx_clock)
        else $error("static config wrong");
    column_ok_a: assert property (!$past(sys_rst_i) && !$past(sys_rst_i, 2)
        && $past(ce_i) && $past(ce_i, 2) |->
        clk_cfg_o.column_tx_ok == $past(tx_master_pll_locked_i, 2)) else $error("column lock");
    unlocked_invalid_a: assert property ((!tx_master_pll_locked_i && ce_i) [*2] |=>
        !data_valid_o) else $error("valid without lock");
    unlocked_hold_a: assert property (!tx_master_pll_locked_i [*3] |=>
        $stable(data_o)) else $error("word moved without lock");
    ce_freeze_a: assert property (!ce_i |=> $stable(data_o)) else $error("ce low moved");
    width_mask_a: assert property ((ce_i && tx_master_pll_locked_i && width_sel_i == PGC_W16) [*4] |->
        data_o[39:16] == 24'h0) else $error("bits above width");
    clk_half_a: assert property ((ce_i && pattern_sel_i == 4'h0 && width_sel_i == PGC_W40
        && !error_inject_i) [*4] ##0 data_valid_o |-> data_o == 40'hAAAAAAAAAA)
        else $error("half rate clock word");
    cover property (data_valid_o && pattern_sel_i == 4'hA);
    cover property (error_inject_i ##1 data_valid_o);
    cover property (!tx_master_pll_locked_i ##1 tx_master_pll_locked_i);
endmodule // pgc_pattern_gen_asserts
bind pgc_pattern_gen pgc_pattern_gen_asserts u_chk (.mclk_i, .sys_rst_i, .ce_i, .pattern_sel_i,
    .width_sel_i, .error_inject_i, .tx_master_pll_locked_i, .data_o, .data_valid_o, .clk_cfg_o);
`default_nettype wire

// >>> pgc_xcvr_model.sv
// Far-side model: transmit PLL lock and a sink counting accepted words
`default_nettype none
module pgc_xcvr_model #(
    parameter int LOCK_DELAY = 5
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic pll_enable_i,
    input wire logic valid_i,
    output logic pll_locked_o,
    output logic [31:0] words_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i || !pll_enable_i) begin
            cnt <= 0;
            pll_locked_o <= 1'b0;
        end else begin
            cnt <= (cnt < LOCK_DELAY) ? cnt + 1 : cnt;
            pll_locked_o <= (cnt >= LOCK_DELAY);
        end
        words_o <= sys_rst_i ? 32'h0 : words_o + {31'h0, valid_i};
    end
endmodule // pgc_xcvr_model
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the pattern generator
`default_nettype none
module testbench import pgc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_i = 0, sys_rst_i = 1, ce = 1, imm = 0, inv = 0, inj = 0, pll_en = 1, valid, lock;
    logic [3:0] sel = 4'h0;
    pgc_width_t wid = PGC_W40;
    logic [39:0] seed = 40'h0, data, d0;
    logic [31:0] words, w0;
    pgc_clk_cfg_t cfg;
    int num_errors = 0, checks_done = 0, cycles = 0;
    int lens[8] = '{7, 9, 11, 15, 20, 23, 29, 31};
    int taps[8] = '{6, 5, 9, 14, 3, 18, 27, 28};
    pgc_pattern_gen DUT (.mclk_i, .sys_rst_i, .ce_i(ce), .pattern_sel_i(sel), .width_sel_i(wid),
        .immediate_mode_i(imm), .seed_i(seed), .invert_i(inv), .error_inject_i(inj),
        .tx_master_pll_locked_i(lock), .data_o(data), .data_valid_o(valid), .clk_cfg_o(cfg));
    pgc_xcvr_model #(.LOCK_DELAY(5)) u_xcvr (.mclk_i, .sys_rst_i, .pll_enable_i(pll_en),
        .valid_i(valid), .pll_locked_o(lock), .words_o(words));
    initial forever #50 mclk_i = ~mclk_i;
    task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
        #5;
    endtask
    // Oldest state bit leaves first, word filled MSB first
    function automatic logic [39:0] prbs(input logic [39:0] s, input int n, t, w);
        logic [39:0] r = 40'h0;
        for (int i = 0; i < w; i++) begin
            r = {r[38:0], s[n-1] ^ s[t-1]};
            s = {s[38:0], r[0]};
        end
        return r;
    endfunction
    task automatic t_config();
        chk("config", {4'h5, 4'hA, 1'h1, 4'h0, 5'h05}, {22'h0, cfg});
        $display("done config");
    endtask
    task automatic t_clocks();
        logic [3:0] s[11] = '{4'h0, 4'h0, 4'h1, 4'h1, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2, 4'h2, 4'hB};
        pgc_width_t w[11] = '{PGC_W40, PGC_W16, PGC_W40, PGC_W20, PGC_W16, PGC_W32, PGC_W40,
            PGC_W32, PGC_W20, PGC_W16, PGC_W40};
        logic [39:0] e[11] = '{40'hAAAAAAAAAA, 40'hAAAA, 40'hF83E0F83E0, 40'hF83E0, 40'hF0F0,
            40'hF0F0F0F0, 40'hFFC00FFC00, 40'hFF00FF00, 40'hFFC00, 40'hFF00, 40'h0};
        for (int i = 0; i < 11; i++) begin
            sel = s[i];
            wid = w[i];
            step(4);
            chk("clock word", e[i], data);
        end
        $display("done clocks");
    endtask
    // Next word must continue the sequence left in the last word
    task automatic t_prbs(input logic flip);
        logic [39:0] m;
        wid = PGC_W40;
        inv = flip;
        for (int k = 0; k < 8; k++) begin
            sel = 4'h3 + 4'(k);
            m = {40{(k > 4) ^ flip}};
            step(4);
            d0 = prbs(data ^ m, lens[k], taps[k], 40) ^ m;
            step(1);
            chk("prbs", d0, data);
        end
        $display("done prbs");
    endtask
    task automatic t_immediate();
        imm = 1;
        inv = 0;
        sel = 4'h3;
        wid = PGC_W16;
        seed = 40'h5A;
        step(3);
        chk("immediate", prbs(40'h5A, 7, 6, 16), data);
        seed = 40'h0;
        step(3);
        chk("zero seed", prbs(40'h7F, 7, 6, 16), data);
        inj = 1;
        step(1);
        chk("inject", prbs(40'h7F, 7, 6, 16) ^ 40'h1, data);
        inj = 0;
        sel = 4'hA;
        wid = PGC_W40;
        seed = 40'h12345678;
        step(3);
        chk("immediate inv", ~prbs(40'h12345678, 31, 28, 40), data);
        $display("done immediate");
    endtask
    task automatic t_lock();
        imm = 0;
        pll_en = 0;
        step(4);
        d0 = data;
        w0 = words;
        chk("valid unlocked", 40'h0, {39'h0, valid});
        step(4);
        chk("held word", d0, data);
        chk("sink words", {8'h0, w0}, {8'h0, words});
        pll_en = 1;
        step(10);
        chk("valid relocked", 40'h1, {39'h0, valid});
        ce = 0;
        d0 = data;
        step(3);
        chk("frozen", d0, data);
        ce = 1;
        $display("done lock");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        step(6);
        sys_rst_i = 0;
        step(12);
        t_config();
        t_clocks();
        t_prbs(1'b0);
        t_prbs(1'b1);
        t_immediate();
        t_lock();
        complete_run();
    end
    // Hang guard, far above the 173 cycles needed
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            complete_run();
        end
    end
endmodule // testbench
`default_nettype wire
